/* design/acse_core.sv */
/*
 * Execution of the accumulator store, pointer load, watchdog restart
 * and accumulator/RAM exchange instructions of a 4-bit core.
 * Assumes instructions arrive one per instr_valid on core_clk and that
 * the sequencer honours skip_next; registers are also reachable over a
 * plain read/write port.
 */
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module acse_core import acse_pkg::*; #(
    parameter int unsigned WD_PERIOD = WD_PERIOD_DEF
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Instruction stream
    input  wire logic       instr_valid,
    input  wire logic [9:0] instr,
    // Register port
    input  wire logic [4:0] reg_addr,
    input  wire logic [3:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [3:0] reg_rdata,
    // Execution status
    output logic            skip_next,
    output logic            wd_flag,
    output logic            wd_running,
    // Control registers toward peripherals, then the accumulator and pointer low nibble
    output logic      [7:0] ext_reg,
    output logic      [3:0] int_edge_ctrl,
    output logic      [3:0] wake_ctrl_0,
    output logic      [3:0] wake_ctrl_1,
    output logic      [3:0] wake_ctrl_2,
    output logic      [3:0] clock_ctrl_reg,
    output logic      [3:0] pullup_ctrl_0,
    output logic      [3:0] pullup_ctrl_1,
    output logic      [3:0] pullup_ctrl_2,
    output logic      [7:0] timer_first_reload,
    output logic      [3:0] irq_ctrl_1,
    output logic      [3:0] irq_ctrl_2,
    output logic      [3:0] timer_ctrl_1,
    output logic      [3:0] timer_ctrl_2,
    output logic      [3:0] timer_ctrl_6,
    output logic      [3:0] acc,
    output logic      [3:0] ptr_low
);
    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] breg;
        logic [3:0] xptr;
        logic [3:0] yptr;
        logic [7:0] ext;
        logic [3:0] int_edge;
        logic [3:0] wake0;
        logic [3:0] wake1;
        logic [3:0] wake2;
        logic [3:0] clk_ctrl;
        logic [3:0] pu0;
        logic [3:0] pu1;
        logic [3:0] pu2;
        logic [7:0] reload;
        logic [3:0] irq1;
        logic [3:0] irq2;
        logic [3:0] tm1;
        logic [3:0] tm2;
        logic [3:0] tm6;
        logic       skip_pend;
        logic       skip_out;
        logic       after_dis;
        logic       wdf;
        logic       wrun;
        logic [3:0] rdata;
    } acse_core_s;

    acse_core_s st;
    acse_core_s next_st;
    logic       exec;
    logic [3:0] imm;
    logic [3:0] rd_val;

    acse_ram_if ram ();
    acse_wd_if  wd ();

    acse_ram #(
        .DEPTH (RAM_WORDS)
    ) u_ram (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .port     (ram.mem)
    );

    acse_watchdog #(
        .PERIOD (WD_PERIOD)
    ) u_wd (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .ctl      (wd.unit)
    );

    // A skipped slot is consumed without effect
    assign exec = instr_valid && !st.skip_pend;
    assign imm  = instr[3:0];

    // Data pointer is X as the high nibble, Y as the low nibble
    assign ram.addr = {st.xptr, st.yptr};

    // Read mux sees the registers before this cycle's update
    always_comb begin
        case (reg_addr)
            RI_ACC:       rd_val = st.acc;
            RI_BREG:      rd_val = st.breg;
            RI_XPTR:      rd_val = st.xptr;
            RI_YPTR:      rd_val = st.yptr;
            RI_EXT_LO:    rd_val = st.ext[3:0];
            RI_EXT_HI:    rd_val = st.ext[7:4];
            RI_INT_EDGE:  rd_val = st.int_edge;
            RI_WAKE0:     rd_val = st.wake0;
            RI_WAKE1:     rd_val = st.wake1;
            RI_WAKE2:     rd_val = st.wake2;
            RI_CLK_CTRL:  rd_val = st.clk_ctrl;
            RI_PU0:       rd_val = st.pu0;
            RI_PU1:       rd_val = st.pu1;
            RI_PU2:       rd_val = st.pu2;
            RI_RELOAD_LO: rd_val = st.reload[3:0];
            RI_RELOAD_HI: rd_val = st.reload[7:4];
            RI_IRQ1:      rd_val = st.irq1;
            RI_IRQ2:      rd_val = st.irq2;
            RI_TM1:       rd_val = st.tm1;
            RI_TM2:       rd_val = st.tm2;
            RI_TM6:       rd_val = st.tm6;
            RI_STATUS: begin
                rd_val              = 4'h0;
                rd_val[ST_WDF_BIT]  = wd.flag;
                rd_val[ST_RUN_BIT]  = wd.running;
                rd_val[ST_SKIP_BIT] = st.skip_pend;
            end
            default:      rd_val = 4'h0;
        endcase
    end

    // Instruction execution; an instruction overrides a port write
    // to the same register in the same cycle
    always_comb begin
        next_st           = st;
        next_st.skip_out  = 1'b0;
        next_st.rdata     = reg_rd ? rd_val : 4'h0;
        next_st.wdf       = wd.flag;
        next_st.wrun      = wd.running;
        ram.we            = 1'b0;
        ram.wdata         = st.acc;
        wd.restart        = 1'b0;
        wd.stop           = 1'b0;
        wd.clear_flag     = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                RI_ACC:  next_st.acc  = reg_wdata;
                RI_BREG: next_st.breg = reg_wdata;
                RI_XPTR: next_st.xptr = reg_wdata;
                RI_YPTR: next_st.yptr = reg_wdata;
                default: ;
            endcase
        end
        if (instr_valid) begin
            next_st.skip_pend = 1'b0;
            next_st.after_dis = exec && (instr == OP_WATCHDOG_DISABLE);
        end
        // One word, one cycle each; no carry exists in this datapath
        if (exec) begin
            case (instr)
                OP_LOAD_EXTENDED_PAIR: next_st.ext      = {st.breg, st.acc};
                OP_LOAD_INT_EDGE_CTRL: next_st.int_edge = st.acc;
                OP_LOAD_WAKE_CTRL_0:   next_st.wake0    = st.acc;
                OP_LOAD_WAKE_CTRL_1:   next_st.wake1    = st.acc;
                OP_LOAD_WAKE_CTRL_2:   next_st.wake2    = st.acc;
                OP_LOAD_CLOCK_CTRL:    next_st.clk_ctrl = st.acc;
                OP_LOAD_PULLUP_CTRL_0: next_st.pu0      = st.acc;
                OP_LOAD_PULLUP_CTRL_1: next_st.pu1      = st.acc;
                OP_LOAD_PULLUP_CTRL_2: next_st.pu2      = st.acc;
                OP_LOAD_RELOAD_PAIR:   next_st.reload   = {st.breg, st.acc};
                OP_LOAD_IRQ_CTRL_1:    next_st.irq1     = st.acc;
                OP_LOAD_IRQ_CTRL_2:    next_st.irq2     = st.acc;
                OP_LOAD_TIMER_CTRL_1:  next_st.tm1      = st.acc;
                OP_LOAD_TIMER_CTRL_2:  next_st.tm2      = st.acc;
                OP_LOAD_TIMER_CTRL_6:  next_st.tm6      = st.acc;
                OP_LOAD_PTR_LOW:       next_st.yptr     = st.acc;
                OP_WATCHDOG_RESTART: begin
                    wd.restart = 1'b1;
                    // Registered flag tested; the restart pre-empts any expiry this cycle
                    if (wd.flag) begin
                        next_st.skip_pend = 1'b1;
                        next_st.skip_out  = 1'b1;
                        wd.clear_flag     = 1'b1;
                    end
                    if (st.after_dis) begin
                        wd.stop = 1'b1;
                    end
                end
                default: begin
                    case (instr[9:4])
                        OPH_STORE_ACC_TO_RAM: begin
                            ram.we       = 1'b1;
                            next_st.xptr = st.xptr ^ imm;
                        end
                        OPH_SWAP_ACC_RAM: begin
                            ram.we       = 1'b1;
                            next_st.acc  = ram.rdata;
                            next_st.xptr = st.xptr ^ imm;
                        end
                        OPH_SWAP_RAM_DEC_SKIP: begin
                            ram.we       = 1'b1;
                            next_st.acc  = ram.rdata;
                            next_st.xptr = st.xptr ^ imm;
                            next_st.yptr = st.yptr - 4'h1;
                            if (st.yptr == 4'h0) begin
                                next_st.skip_pend = 1'b1;
                                next_st.skip_out  = 1'b1;
                            end
                        end
                        OPH_SWAP_RAM_INC_SKIP: begin
                            ram.we       = 1'b1;
                            next_st.acc  = ram.rdata;
                            next_st.xptr = st.xptr ^ imm;
                            next_st.yptr = st.yptr + 4'h1;
                            if (st.yptr == 4'hf) begin
                                next_st.skip_pend = 1'b1;
                                next_st.skip_out  = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
            endcase
        end
    end

    // Single state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st      <= '0;
            st.wrun <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign reg_rdata          = st.rdata;
    assign skip_next          = st.skip_out;
    assign wd_flag            = st.wdf;
    assign wd_running         = st.wrun;
    assign ext_reg            = st.ext;
    assign int_edge_ctrl      = st.int_edge;
    assign wake_ctrl_0        = st.wake0;
    assign wake_ctrl_1        = st.wake1;
    assign wake_ctrl_2        = st.wake2;
    assign clock_ctrl_reg     = st.clk_ctrl;
    assign pullup_ctrl_0      = st.pu0;
    assign pullup_ctrl_1      = st.pu1;
    assign pullup_ctrl_2      = st.pu2;
    assign timer_first_reload = st.reload;
    assign irq_ctrl_1         = st.irq1;
    assign irq_ctrl_2         = st.irq2;
    assign timer_ctrl_1       = st.tm1;
    assign timer_ctrl_2       = st.tm2;
    assign timer_ctrl_6       = st.tm6;
    assign acc                = st.acc;
    assign ptr_low            = st.yptr;
endmodule
`default_nettype wire

/* design/acse_pkg.sv */
/*
 * Shared constants for the accumulator store and exchange execution group:
 * opcodes, register indices, reset values and timing defaults.
 * Assumes a 10-bit instruction word and 4-bit data path.
 */
`default_nettype none
package acse_pkg;
    localparam int unsigned NIB_W    = 4;
    localparam int unsigned INSTR_W  = 10;
    localparam int unsigned RAM_AW   = 8;
    localparam int unsigned RAM_WORDS = 256;
    localparam int unsigned REG_AW   = 5;

    // Fixed opcodes
    localparam logic [9:0] OP_LOAD_EXTENDED_PAIR = 10'h01a;
    localparam logic [9:0] OP_LOAD_INT_EDGE_CTRL = 10'h217;
    localparam logic [9:0] OP_LOAD_WAKE_CTRL_0   = 10'h21b;
    localparam logic [9:0] OP_LOAD_WAKE_CTRL_1   = 10'h214;
    localparam logic [9:0] OP_LOAD_WAKE_CTRL_2   = 10'h215;
    localparam logic [9:0] OP_LOAD_CLOCK_CTRL    = 10'h216;
    localparam logic [9:0] OP_LOAD_PULLUP_CTRL_0 = 10'h22d;
    localparam logic [9:0] OP_LOAD_PULLUP_CTRL_1 = 10'h22e;
    localparam logic [9:0] OP_LOAD_PULLUP_CTRL_2 = 10'h22f;
    localparam logic [9:0] OP_LOAD_RELOAD_PAIR   = 10'h23f;
    localparam logic [9:0] OP_LOAD_IRQ_CTRL_1    = 10'h03f;
    localparam logic [9:0] OP_LOAD_IRQ_CTRL_2    = 10'h03e;
    localparam logic [9:0] OP_LOAD_TIMER_CTRL_1  = 10'h20e;
    localparam logic [9:0] OP_LOAD_TIMER_CTRL_2  = 10'h20f;
    localparam logic [9:0] OP_LOAD_TIMER_CTRL_6  = 10'h227;
    localparam logic [9:0] OP_LOAD_PTR_LOW       = 10'h00c;
    localparam logic [9:0] OP_WATCHDOG_RESTART   = 10'h2a0;
    localparam logic [9:0] OP_WATCHDOG_DISABLE   = 10'h29c;

    // Opcodes with a 4-bit immediate in bits 3..0, matched on bits 9..4
    localparam logic [5:0] OPH_STORE_ACC_TO_RAM  = 6'h2b;
    localparam logic [5:0] OPH_SWAP_ACC_RAM      = 6'h2d;
    localparam logic [5:0] OPH_SWAP_RAM_INC_SKIP = 6'h2e;
    localparam logic [5:0] OPH_SWAP_RAM_DEC_SKIP = 6'h2f;

    // Register port indices
    localparam logic [4:0] RI_ACC       = 5'h00;
    localparam logic [4:0] RI_BREG      = 5'h01;
    localparam logic [4:0] RI_XPTR      = 5'h02;
    localparam logic [4:0] RI_YPTR      = 5'h03;
    localparam logic [4:0] RI_EXT_LO    = 5'h04;
    localparam logic [4:0] RI_EXT_HI    = 5'h05;
    localparam logic [4:0] RI_INT_EDGE  = 5'h06;
    localparam logic [4:0] RI_WAKE0     = 5'h07;
    localparam logic [4:0] RI_WAKE1     = 5'h08;
    localparam logic [4:0] RI_WAKE2     = 5'h09;
    localparam logic [4:0] RI_CLK_CTRL  = 5'h0a;
    localparam logic [4:0] RI_PU0       = 5'h0b;
    localparam logic [4:0] RI_PU1       = 5'h0c;
    localparam logic [4:0] RI_PU2       = 5'h0d;
    localparam logic [4:0] RI_RELOAD_LO = 5'h0e;
    localparam logic [4:0] RI_RELOAD_HI = 5'h0f;
    localparam logic [4:0] RI_IRQ1      = 5'h10;
    localparam logic [4:0] RI_IRQ2      = 5'h11;
    localparam logic [4:0] RI_TM1       = 5'h12;
    localparam logic [4:0] RI_TM2       = 5'h13;
    localparam logic [4:0] RI_TM6       = 5'h14;
    localparam logic [4:0] RI_STATUS    = 5'h15;

    // Status bit positions
    localparam int unsigned ST_WDF_BIT  = 0;
    localparam int unsigned ST_RUN_BIT  = 1;
    localparam int unsigned ST_SKIP_BIT = 2;

    // Reset values
    localparam logic [3:0] NIB_RST  = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Watchdog period in core clock cycles
    localparam int unsigned WD_PERIOD_DEF = 65536;

    // True when the upper six opcode bits select an immediate-form op
    function automatic logic imm_op(input logic [9:0] ins, input logic [5:0] hi);
        return ins[9:4] == hi;
    endfunction
endpackage
`default_nettype wire

/* design/acse_if.sv */
/*
 * Internal carriers: RAM port and watchdog control between the core
 * and its two leaf modules. Assumes all ends run on core_clk.
 */
`timescale 1ns/10ps
`default_nettype none
interface acse_ram_if;
    logic [7:0] addr;
    logic [3:0] wdata;
    logic       we;
    logic [3:0] rdata;
    modport core (output addr, output wdata, output we, input rdata);
    modport mem  (input addr, input wdata, input we, output rdata);
endinterface

interface acse_wd_if;
    logic restart;
    logic stop;
    logic clear_flag;
    logic flag;
    logic running;
    modport core (output restart, output stop, output clear_flag,
                  input flag, input running);
    modport unit (input restart, input stop, input clear_flag,
                  output flag, output running);
endinterface
`default_nettype wire

/* design/acse_ram.sv */
/*
 * Nibble-wide data RAM addressed by the data pointer.
 * Assumes writes are one-cycle strobes; read is combinational.
 */
`timescale 1ns/10ps
`default_nettype none
module acse_ram import acse_pkg::*; #(
    parameter int unsigned DEPTH = RAM_WORDS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Access port
    acse_ram_if.mem  port
);
    typedef struct packed {
        logic [DEPTH-1:0][3:0] mem;
    } acse_ram_s;

    acse_ram_s st;
    acse_ram_s next_st;

    // The pointer reaches exactly the whole array, no more, no less
    if (DEPTH != (1 << RAM_AW)) begin : g_bad_depth
        $error("acse_ram: DEPTH must equal 2**RAM_AW");
    end

    assign port.rdata = st.mem[port.addr];

    // Single write port
    always_comb begin
        next_st = st;
        if (port.we) begin
            next_st.mem[port.addr] = port.wdata;
        end
    end

    // Cleared at reset so reads are never undefined
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

/* design/acse_watchdog.sv */
/*
 * Watchdog counter: raises its flag at each period end,
 * restarts on command and stops for good once told to.
 * Assumes command strobes are one cycle long on core_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module acse_watchdog import acse_pkg::*; #(
    parameter int unsigned PERIOD = WD_PERIOD_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Control
    acse_wd_if.unit  ctl
);
    localparam int unsigned CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    if (PERIOD < 2) begin : g_bad_period
        $error("acse_watchdog: PERIOD must be at least 2");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          flag;
        logic          running;
    } acse_wd_s;

    acse_wd_s st;
    acse_wd_s next_st;

    assign ctl.flag    = st.flag;
    assign ctl.running = st.running;

    // Count, expire, clear; an expiry beats a clear in the same cycle
    always_comb begin
        next_st = st;
        if (ctl.clear_flag) begin
            next_st.flag = 1'b0;
        end
        if (ctl.stop) begin
            next_st.running = 1'b0;
            next_st.cnt     = '0;
        end else if (ctl.restart) begin
            next_st.cnt = '0;
        end else if (st.running) begin
            if (st.cnt == LAST) begin
                next_st.cnt  = '0;
                next_st.flag = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    // Runs from reset onward
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{cnt: '0, flag: 1'b0, running: 1'b1};
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

/* test/acse_core_assertions.sv */
/*
 * Checker for the store and exchange group: one cycle per op, skips.
 * Sees only acse_core ports; bound into every acse_core below.
 */
`timescale 1ns/10ps
`default_nettype none
module acse_core_assertions import acse_pkg::*; #(
    parameter int unsigned WD_PERIOD = WD_PERIOD_DEF
) (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    // Instruction stream and status
    input wire logic       instr_valid,
    input wire logic [9:0] instr,
    input wire logic       skip_next,
    input wire logic       wd_running,
    // Loaded registers
    input wire logic [7:0] ext_reg,
    input wire logic [7:0] timer_first_reload,
    input wire logic [3:0] int_edge_ctrl,
    input wire logic [3:0] clock_ctrl_reg,
    input wire logic [3:0] timer_ctrl_6,
    input wire logic [3:0] acc,
    input wire logic [3:0] ptr_low
);
    logic pend_q;
    logic dis_q;
    logic live;

    // A pending skip outlives idle cycles, so track it until the next op
    assign live = instr_valid && !(pend_q || skip_next);

    // Pending skip and "previous op was a disable" trackers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_q <= 1'b0;
            dis_q  <= 1'b0;
        end else begin
            pend_q <= instr_valid ? 1'b0 : (pend_q | skip_next);
            if (instr_valid) begin
                dis_q <= live && (instr == OP_WATCHDOG_DISABLE);
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    a_ext_pair_low: assert property (
        live && instr == OP_LOAD_EXTENDED_PAIR |=> ext_reg[3:0] == $past(acc))
        else $error("extended low nibble not the accumulator");
    a_int_edge_load: assert property (
        live && instr == OP_LOAD_INT_EDGE_CTRL |=> int_edge_ctrl == $past(acc))
        else $error("interrupt edge register not loaded");
    a_clock_load: assert property (
        live && instr == OP_LOAD_CLOCK_CTRL |=> clock_ctrl_reg == $past(acc))
        else $error("clock control register not loaded");
    a_reload_low: assert property (
        live && instr == OP_LOAD_RELOAD_PAIR |=> timer_first_reload[3:0] == $past(acc))
        else $error("reload low nibble not the accumulator");
    a_timer_six_load: assert property (
        live && instr == OP_LOAD_TIMER_CTRL_6 |=> timer_ctrl_6 == $past(acc))
        else $error("timer control six not loaded");
    a_ptr_load: assert property (
        live && instr == OP_LOAD_PTR_LOW |=> ptr_low == $past(acc))
        else $error("pointer not loaded from accumulator");
    a_dec_skip: assert property (
        live && instr[9:4] == OPH_SWAP_RAM_DEC_SKIP |=>
        ptr_low == $past(ptr_low) - 4'h1 && skip_next == ($past(ptr_low) == 4'h0))
        else $error("decrement or its skip wrong");
    a_inc_skip: assert property (
        live && instr[9:4] == OPH_SWAP_RAM_INC_SKIP |=>
        ptr_low == $past(ptr_low) + 4'h1 && skip_next == ($past(ptr_low) == 4'hf))
        else $error("increment or its skip wrong");
    a_wd_stop: assert property (
        live && dis_q && instr == OP_WATCHDOG_RESTART |-> ##2 !wd_running)
        else $error("watchdog still running after disable and restart");

    // Main scenarios reached
    c_dec_skip: cover property (live && instr[9:4] == OPH_SWAP_RAM_DEC_SKIP ##1 skip_next);
    c_consumed: cover property (instr_valid && skip_next);
    c_stop: cover property (live && dis_q && instr == OP_WATCHDOG_RESTART);
endmodule

bind acse_core acse_core_assertions #(.WD_PERIOD(WD_PERIOD)) i_acse_core_assertions (
    .core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
    .skip_next(skip_next), .wd_running(wd_running), .ext_reg(ext_reg),
    .timer_first_reload(timer_first_reload), .int_edge_ctrl(int_edge_ctrl),
    .clock_ctrl_reg(clock_ctrl_reg), .timer_ctrl_6(timer_ctrl_6), .acc(acc),
    .ptr_low(ptr_low));
`default_nettype wire

/* test/acse_core_tb_top.sv */
/*
 * Self-checking bench for acse_core: drives instructions and the register
 * port directly. Assumes the package opcodes and register indices.
 */
`timescale 1ns/10ps
`default_nettype none
module acse_core_tb_top import acse_pkg::*;;
    logic       core_clk, reset_n, instr_valid, reg_wr, reg_rd;
    logic       skip_next, wd_flag, wd_running;
    logic [9:0] instr;
    logic [4:0] reg_addr;
    logic [3:0] reg_wdata, reg_rdata, acc;
    logic [7:0] ext_reg, timer_first_reload;
    logic [3:0] outs [14];
    int         mismatches = 0;
    int         n_checks = 0;
    // Plain loads, in the same order as outs
    localparam logic [9:0] OPS [14] = '{OP_LOAD_INT_EDGE_CTRL, OP_LOAD_WAKE_CTRL_0,
        OP_LOAD_WAKE_CTRL_1, OP_LOAD_WAKE_CTRL_2, OP_LOAD_CLOCK_CTRL, OP_LOAD_PULLUP_CTRL_0,
        OP_LOAD_PULLUP_CTRL_1, OP_LOAD_PULLUP_CTRL_2, OP_LOAD_IRQ_CTRL_1, OP_LOAD_IRQ_CTRL_2,
        OP_LOAD_TIMER_CTRL_1, OP_LOAD_TIMER_CTRL_2, OP_LOAD_TIMER_CTRL_6, OP_LOAD_PTR_LOW};

    // Short watchdog period keeps expiry waits brief
    acse_core #(.WD_PERIOD(8)) i_acse_core (
        .core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .skip_next(skip_next), .wd_flag(wd_flag),
        .wd_running(wd_running), .ext_reg(ext_reg), .int_edge_ctrl(outs[0]),
        .wake_ctrl_0(outs[1]), .wake_ctrl_1(outs[2]), .wake_ctrl_2(outs[3]),
        .clock_ctrl_reg(outs[4]), .pullup_ctrl_0(outs[5]), .pullup_ctrl_1(outs[6]),
        .pullup_ctrl_2(outs[7]), .timer_first_reload(timer_first_reload),
        .irq_ctrl_1(outs[8]), .irq_ctrl_2(outs[9]), .timer_ctrl_1(outs[10]),
        .timer_ctrl_2(outs[11]), .timer_ctrl_6(outs[12]), .acc(acc), .ptr_low(outs[13]));

    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [3:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    task automatic ex(input logic [9:0] op);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr       <= op;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // Two ops back to back; skip pulse checked while the second is taken
    task automatic pair(input logic [9:0] a, input logic [9:0] b, input logic sk);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr       <= a;
        @(posedge core_clk);
        instr <= b;
        #1 chk(skip_next, sk);
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole sequence takes well under 1000 cycles
    initial begin
        #50000;
        mismatches++;
        finish_test();
    end

    initial begin
        {reset_n, instr_valid, reg_wr, reg_rd, instr, reg_addr, reg_wdata} = '0;
        repeat (8) @(posedge core_clk);
        chk(ext_reg, 8'h00);
        chk(wd_running, 1'b1);
        reset_n <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            wr(RI_ACC, 4'(i + 1));
            ex(OPS[i]);
        end
        for (int i = 0; i < 14; i++) begin
            chk(outs[i], 8'(i + 1));
        end
        wr(RI_BREG, 4'ha);
        wr(RI_ACC, 4'h5);
        ex(OP_LOAD_EXTENDED_PAIR);
        chk(ext_reg, 8'ha5);
        wr(RI_BREG, 4'h3);
        wr(RI_ACC, 4'hc);
        ex(OP_LOAD_RELOAD_PAIR);
        chk(timer_first_reload, 8'h3c);
        rd(5'h1f, 4'h0);
        $display("load tests done");
        // RAM at pointer {2,0}: store, two swaps, a decrement skip swap; then increment skip swaps
        wr(RI_XPTR, 4'h2);
        wr(RI_YPTR, 4'h0);
        wr(RI_ACC, 4'h9);
        ex({OPH_STORE_ACC_TO_RAM, 4'h6});
        rd(RI_XPTR, 4'h4);
        wr(RI_XPTR, 4'h2);
        wr(RI_ACC, 4'h1);
        ex({OPH_SWAP_ACC_RAM, 4'h0});
        chk(acc, 8'h09);
        ex({OPH_SWAP_ACC_RAM, 4'h5});
        chk(acc, 8'h01);
        rd(RI_XPTR, 4'h7);
        wr(RI_XPTR, 4'h2);
        pair({OPH_SWAP_RAM_DEC_SKIP, 4'h1}, OP_LOAD_PTR_LOW, 1'b1);
        chk(outs[13], 8'h0f);
        chk(acc, 8'h09);
        rd(RI_XPTR, 4'h3);
        pair({OPH_SWAP_RAM_INC_SKIP, 4'h0}, OP_LOAD_PTR_LOW, 1'b1);
        chk(outs[13], 8'h00);
        chk(acc, 8'h00);
        pair({OPH_SWAP_RAM_INC_SKIP, 4'h0}, OP_LOAD_PTR_LOW, 1'b0);
        chk(outs[13], 8'h00);
        $display("exchange tests done");
        // Watchdog: restart with flag set, then clear, then stop
        for (int k = 0; k < 40 && wd_flag !== 1'b1; k++) begin
            @(posedge core_clk);
        end
        wr(RI_ACC, 4'h5);
        pair(OP_WATCHDOG_RESTART, OP_LOAD_PTR_LOW, 1'b1);
        chk(outs[13], 8'h00);
        chk(wd_flag, 1'b0);
        pair(OP_WATCHDOG_RESTART, OP_LOAD_PTR_LOW, 1'b0);
        chk(outs[13], 8'h05);
        pair(OP_WATCHDOG_DISABLE, OP_WATCHDOG_RESTART, 1'b0);
        repeat (2) @(posedge core_clk);
        #1 chk(wd_running, 1'b0);
        repeat (20) @(posedge core_clk);
        #1 chk(wd_flag, 1'b0);
        $display("watchdog tests done");
        finish_test();
    end
endmodule
`default_nettype wire
